// File: drt_refresh_timing.sv
// Command decode, bank state tracking, refresh bookkeeping and self refresh entry
`timescale 1ns/1ps
module drt_refresh_timing
  import drt_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // Command/address bus, synchronous to sys_clk
  input  wire logic              cke,
  input  wire logic              cs,
  input  wire logic [5:0]        ca,
  // Count synchronisation events
  input  wire logic              reset_cmd,
  input  wire logic              sr_exit,
  // Status
  output logic                   cmd_accept,
  output logic                   cmd_reject,
  output logic [NBANK-1:0]       bank_active,
  output logic [NBANK-1:0]       bank_refreshing,
  output logic [NBANK-1:0]       per_bank_refresh_mask,
  output logic                   all_bank_refresh_busy,
  output logic                   self_refresh,
  output logic signed [4:0]      refresh_balance,
  output logic                   balance_err
);
  drt_bank_e          bank_r   [NBANK];
  drt_bank_e          bank_nxt [NBANK];
  logic [NBANK-1:0]   ld;
  logic [TW-1:0]      ldv      [NBANK];
  logic [NBANK-1:0]   busy;
  drt_cmd_e           kind_r, kind_nxt;
  logic               ph2_r, ph2_nxt;
  logic               ab_r, ab_nxt;
  logic [NBANK-1:0]   mask_r, mask_nxt;
  logic [TW-1:0]      all_bank_refresh_r, all_bank_refresh_nxt;
  logic [TW-1:0]      wr2rd_r, wr2rd_nxt;
  logic [TW-1:0]      pregap_r, pregap_nxt;
  logic [TW-1:0]      refi_r, refi_nxt;
  logic               sr_r, sr_nxt;
  logic signed [4:0]  bal_r, bal_nxt;
  logic               acc_r, acc_nxt;
  logic               rej_r, rej_nxt;
  logic               idle_all;
  logic               ref_ok;
  logic [2:0]         bsel;

  drt_tmr_if tif [NBANK] ();

  genvar g;
  generate
    for (g = 0; g < NBANK; g++)
    begin : g_bank
      assign tif[g].load        = ld[g];
      assign tif[g].val         = ldv[g];
      assign busy[g]            = tif[g].busy;
      assign bank_active[g]     = (bank_r[g] == BK_ACTIVE);
      assign bank_refreshing[g] = (bank_r[g] == BK_PER_BANK_REFRESH);
      drt_bank_timer u_tmr (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .t       (tif[g])
      );
    end
  endgenerate

  assign bsel = ca[2:0];

  always_comb
  begin
    idle_all = 1'b1;
    for (int i = 0; i < NBANK; i++)
      if (!bank_ready(bank_r[i], busy[i]))
        idle_all = 1'b0;
  end

  always_comb
  begin
    logic ok;
    logic pre_hit;
    ok          = 1'b0;
    pre_hit     = 1'b0;
    kind_nxt    = C_NONE;
    ph2_nxt     = 1'b0;
    ab_nxt      = 1'b0;
    mask_nxt    = mask_r;
    all_bank_refresh_nxt   = (all_bank_refresh_r != '0) ? all_bank_refresh_r - TW'(1) : all_bank_refresh_r;
    wr2rd_nxt   = (wr2rd_r != '0) ? wr2rd_r - TW'(1) : wr2rd_r;
    pregap_nxt  = (pregap_r != '0) ? pregap_r - TW'(1) : pregap_r;
    sr_nxt      = sr_r;
    ref_ok      = 1'b0;
    acc_nxt     = 1'b0;
    rej_nxt     = 1'b0;
    ld          = '0;
    for (int i = 0; i < NBANK; i++)
    begin
      bank_nxt[i] = bank_r[i];
      ldv[i]      = '0;
      if ((bank_r[i] == BK_PRECH || bank_r[i] == BK_PER_BANK_REFRESH) && !busy[i])
        bank_nxt[i] = BK_IDLE;
      if (bank_r[i] == BK_WRAP && !busy[i])
      begin
        bank_nxt[i] = BK_PRECH;
        ld[i]       = 1'b1;
        ldv[i]      = LD_RPPB;
      end
    end
    // First edge; the decode waits for the second edge before acting
    if (!ph2_r && cke && cs)
    begin
      kind_nxt = cmd_decode(ca);
      ph2_nxt  = (cmd_decode(ca) != C_NONE);
      ab_nxt   = ca[5];
    end
    if (ph2_r)
    begin
      case (kind_r)
        C_ACT:
        begin
          ok = !sr_r && bank_ready(bank_r[bsel], busy[bsel]) && all_bank_refresh_r == '0;
          if (ok)
            bank_nxt[bsel] = BK_ACTIVE;
        end
        C_RD:
        begin
          ok = !sr_r && bank_r[bsel] == BK_ACTIVE && wr2rd_r == '0;
          if (ok && ca[5])
          begin
            bank_nxt[bsel] = BK_PRECH;
            ld[bsel]       = 1'b1;
            ldv[bsel]      = LD_RDAP;
          end
        end
        C_WR, C_MWR:
        begin
          ok = !sr_r && bank_r[bsel] == BK_ACTIVE;
          if (ok)
            wr2rd_nxt = LD_WR2RD;
          if (ok && ca[5])
          begin
            bank_nxt[bsel] = BK_WRAP;
            ld[bsel]       = 1'b1;
            ldv[bsel]      = LD_WRAP;
          end
        end
        C_PRE:
        begin
          ok = !sr_r && pregap_r == '0;
          for (int i = 0; i < NBANK; i++)
            // The last lockout cycle is already legal, so only a running timer refuses
            if ((ab_r || bsel == 3'(i)) && (bank_r[i] == BK_WRAP || bank_r[i] == BK_PER_BANK_REFRESH)
                && busy[i])
              ok = 1'b0;
          if (ok)
          begin
            pregap_nxt = LD_PREG;
            for (int i = 0; i < NBANK; i++)
            begin
              pre_hit = ab_r || bsel == 3'(i);
              if (pre_hit)
              begin
                bank_nxt[i] = BK_PRECH;
                ld[i]       = 1'b1;
                ldv[i]      = ab_r ? LD_RPAB : LD_RPPB;
              end
            end
          end
        end
        C_REF:
        begin
          if (ab_r)
          begin
            ok = !sr_r && idle_all && all_bank_refresh_r == '0;
            if (ok)
            begin
              for (int i = 0; i < NBANK; i++)
                bank_nxt[i] = BK_IDLE;
              all_bank_refresh_nxt = LD_RFCAB;
              mask_nxt  = '0;
            end
          end
          else
          begin
            ok = !sr_r && bank_ready(bank_r[bsel], busy[bsel]) && all_bank_refresh_r == '0
                 && !mask_r[bsel];
            if (ok)
            begin
              bank_nxt[bsel] = BK_PER_BANK_REFRESH;
              ld[bsel]       = 1'b1;
              ldv[bsel]      = LD_RFCPB;
              mask_nxt[bsel] = 1'b1;
              if (&mask_nxt)
                mask_nxt = '0;
            end
          end
          ref_ok = ok;
        end
        C_SRE:
        begin
          ok = !sr_r && cke && !cs && idle_all && all_bank_refresh_r == '0;
          if (ok)
            sr_nxt = 1'b1;
        end
        default: ok = 1'b0;
      endcase
      acc_nxt = ok;
      rej_nxt = !ok;
    end
    if (sr_exit && sr_r)
    begin
      sr_nxt   = 1'b0;
      mask_nxt = '0;
    end
    if (reset_cmd)
      mask_nxt = '0;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NBANK; i++)
        bank_r[i] <= BK_IDLE;
      kind_r   <= C_NONE;
      ph2_r    <= 1'b0;
      ab_r     <= 1'b0;
      mask_r   <= '0;
      all_bank_refresh_r  <= '0;
      wr2rd_r  <= '0;
      pregap_r <= '0;
      sr_r     <= 1'b0;
      acc_r    <= 1'b0;
      rej_r    <= 1'b0;
    end
    else
    begin
      bank_r   <= bank_nxt;
      kind_r   <= kind_nxt;
      ph2_r    <= ph2_nxt;
      ab_r     <= ab_nxt;
      mask_r   <= mask_nxt;
      all_bank_refresh_r  <= all_bank_refresh_nxt;
      wr2rd_r  <= wr2rd_nxt;
      pregap_r <= pregap_nxt;
      sr_r     <= sr_nxt;
      acc_r    <= acc_nxt;
      rej_r    <= rej_nxt;
    end
  end

  // Balance counts issued refreshes against elapsed intervals; frozen in self refresh
  always_comb
  begin
    refi_nxt = (refi_r == '0) ? LD_REFI : refi_r - TW'(1);
    bal_nxt  = bal_r;
    if (!sr_r)
    begin
      if (ref_ok && refi_r != '0)
        bal_nxt = bal_r + 5'sd1;
      else if (!ref_ok && refi_r == '0)
        bal_nxt = bal_r - 5'sd1;
    end
    else
      bal_nxt = bal_r;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      refi_r <= LD_REFI;
      bal_r  <= '0;
    end
    else
    begin
      refi_r <= refi_nxt;
      bal_r  <= bal_nxt;
    end
  end

  assign cmd_accept      = acc_r;
  assign cmd_reject      = rej_r;
  assign per_bank_refresh_mask      = mask_r;
  assign all_bank_refresh_busy      = (all_bank_refresh_r != '0);
  assign self_refresh    = sr_r;
  assign refresh_balance = bal_r;
  // Counter only wraps far beyond the limit, which this flag reports first
  assign balance_err     = (bal_r > 5'sd8) || (bal_r < -5'sd8);

  sequence sre_seq;
    (!ph2_r && !sr_r && cke && cs && ca[4:0] == CMD_SRE) ##1 (cke && !cs);
  endsequence
  sequence per_bank_refresh_seq;
    (!ph2_r && cke && cs && ca[4:0] == CMD_REF && !ca[5]) ##1 1'b1;
  endsequence

  chk_ref_decode: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!ph2_r && cke && cs && ca[4:0] == CMD_REF) |=> (ph2_r && kind_r == C_REF
      && ab_r == $past(ca[5])))
    else $error("refresh first edge not decoded");
  chk_per_bank_refresh_bank: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (per_bank_refresh_seq ##0 (!sr_r && bank_r[bsel] == BK_IDLE && all_bank_refresh_r == '0 && !mask_r[bsel]))
      |=> (bank_r[$past(bsel)] == BK_PER_BANK_REFRESH && cmd_accept))
    else $error("per-bank refresh hit wrong bank");
  chk_all_bank_refresh_sync: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ph2_r && kind_r == C_REF && ab_r && ref_ok) |=> (per_bank_refresh_mask == '0 && all_bank_refresh_busy))
    else $error("all-bank refresh did not clear bank count");
  chk_per_bank_refresh_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ph2_r && kind_r inside {C_ACT, C_RD, C_WR, C_MWR} && bank_r[bsel] == BK_PER_BANK_REFRESH
      && busy[bsel]) |=> cmd_reject)
    else $error("access to refreshing bank accepted");
  chk_all_bank_refresh_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ph2_r && kind_r == C_REF && ab_r && ref_ok) |=> (bank_active == '0
      && bank_refreshing == '0) ##1 all_bank_refresh_busy)
    else $error("banks not idle after all-bank refresh");
  chk_sr_freeze: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sr_r && $past(sr_r)) |-> $stable(refresh_balance))
    else $error("refresh balance moved in self refresh");
  chk_sr_entry: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sre_seq |=> (self_refresh == $past(idle_all && all_bank_refresh_r == '0)))
    else $error("self refresh entry mishandled");
  chk_wrap_lock: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ph2_r && kind_r == C_WR && ca[5] && bsel == 3'h0 && acc_nxt)
      |=> (bank_r[0] == BK_WRAP) ##17 (bank_r[0] == BK_WRAP) ##1 (bank_r[0] == BK_PRECH))
    else $error("write auto precharge lockout length wrong");
  chk_pre_gap: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ph2_r && kind_r == C_PRE && acc_nxt) |=> (pregap_r == LD_PREG) ##1 (pregap_r != '0))
    else $error("precharge spacing not armed");
  chk_wtr_lock: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ph2_r && kind_r == C_RD && wr2rd_r != '0) |=> cmd_reject)
    else $error("read inside write-to-read lockout accepted");

endmodule : drt_refresh_timing

// File: drt_pkg.sv
// Shared constants, types and decode helpers for the refresh and precharge timing block
package drt_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int NBANK         = 8;
  localparam int TW            = 8;

  // Times in ns (WL_CK in clocks, BL in beats), rounded up to clocks below except the refresh interval
  localparam int T_RFCAB_NS = 280;
  localparam int T_RFCPB_NS = 140;
  localparam int T_RPAB_NS  = 21;
  localparam int T_RPPB_NS  = 18;
  localparam int T_WR_NS    = 18;
  localparam int T_WTR_NS   = 10;
  localparam int T_REFI_NS  = 3904;
  localparam int WL_CK      = 8;
  localparam int BL         = 16;

  function automatic int ru(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction : ru

  localparam int RFCAB_CK   = ru(T_RFCAB_NS);
  localparam int RFCPB_CK   = ru(T_RFCPB_NS);
  localparam int RPAB_CK    = ru(T_RPAB_NS);
  localparam int RPPB_CK    = ru(T_RPPB_NS);
  localparam int WRAP_CK    = WL_CK + BL / 2 + ru(T_WR_NS) + 1;
  localparam int WR2RD_CK   = WL_CK + BL / 2 + ru(T_WTR_NS) + 1;
  localparam int PRE_GAP_CK = 4;
  // Refresh interval rounds down: it is the longest time between refreshes
  localparam int REFI_CK    = T_REFI_NS / CLK_PERIOD_NS;
  localparam int BAL_LIMIT  = 8;

  // Timer loads hold the count minus one: the lockout ends on the count's last edge
  localparam logic [TW-1:0] LD_RFCAB = TW'(RFCAB_CK - 1);
  localparam logic [TW-1:0] LD_RFCPB = TW'(RFCPB_CK - 1);
  localparam logic [TW-1:0] LD_RPAB  = TW'(RPAB_CK - 1);
  localparam logic [TW-1:0] LD_RPPB  = TW'(RPPB_CK - 1);
  localparam logic [TW-1:0] LD_WRAP  = TW'(WRAP_CK - 1);
  localparam logic [TW-1:0] LD_RDAP  = TW'(BL / 2 + RPPB_CK - 1);
  localparam logic [TW-1:0] LD_WR2RD = TW'(WR2RD_CK - 1);
  localparam logic [TW-1:0] LD_PREG  = TW'(PRE_GAP_CK - 1);
  localparam logic [TW-1:0] LD_REFI  = TW'(REFI_CK - 1);

  // First-edge command codes on command/address bits 4..0; activate uses bits 1..0 only
  localparam logic [1:0] CMD_ACT = 2'h1;
  localparam logic [4:0] CMD_RD  = 5'h02;
  localparam logic [4:0] CMD_WR  = 5'h04;
  localparam logic [4:0] CMD_MWR = 5'h0C;
  localparam logic [4:0] CMD_REF = 5'h08;
  localparam logic [4:0] CMD_SRE = 5'h18;
  localparam logic [4:0] CMD_PRE = 5'h10;

  typedef enum logic [2:0] {BK_IDLE, BK_ACTIVE, BK_WRAP, BK_PRECH, BK_PER_BANK_REFRESH} drt_bank_e;
  typedef enum logic [2:0] {C_NONE, C_ACT, C_RD, C_WR, C_MWR, C_PRE, C_REF, C_SRE} drt_cmd_e;

  function automatic drt_cmd_e cmd_decode(input logic [5:0] ca);
    drt_cmd_e c;
    c = C_NONE;
    if (ca[1:0] == CMD_ACT)
      c = C_ACT;
    else
    begin
      case (ca[4:0])
        CMD_RD:  c = C_RD;
        CMD_WR:  c = C_WR;
        CMD_MWR: c = C_MWR;
        CMD_PRE: c = C_PRE;
        CMD_REF: c = C_REF;
        CMD_SRE: c = C_SRE;
        default: c = C_NONE;
      endcase
    end
    return c;
  endfunction : cmd_decode

  // A bank is ready once idle or on the last cycle of its precharge or refresh
  function automatic logic bank_ready(input drt_bank_e st, input logic busy);
    return (st == BK_IDLE) || ((st == BK_PRECH || st == BK_PER_BANK_REFRESH) && !busy);
  endfunction : bank_ready

endpackage : drt_pkg

// File: drt_tmr_if.sv
// Load and status signals between the controller and one bank lockout timer
`timescale 1ns/1ps
interface drt_tmr_if;
  logic                   load;
  logic [drt_pkg::TW-1:0] val;
  logic                   busy;
  modport ctl (output load, output val, input busy);
  modport tmr (input load, input val, output busy);
endinterface : drt_tmr_if

// File: drt_bank_timer.sv
// Down-counting lockout timer for one bank
`timescale 1ns/1ps
module drt_bank_timer
  import drt_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control side
  drt_tmr_if.tmr   t
);
  logic [TW-1:0] cnt_r;
  logic [TW-1:0] cnt_nxt;

  // A reload always restarts the period, so the latest command wins
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (t.load)
      cnt_nxt = t.val;
    else if (cnt_r != '0)
      cnt_nxt = cnt_r - TW'(1);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign t.busy = (cnt_r != '0);

  chk_reload_counts: assert property (@(posedge sys_clk) disable iff (sys_rst)
    t.load |=> cnt_r == $past(t.val))
    else $error("timer did not take its reload value");

endmodule : drt_bank_timer

// File: drt_ctl_model.sv
// Command bus driver standing in for the memory controller
`timescale 1ns/1ps
module drt_ctl_model
(
  // Clock
  input  wire logic       sys_clk,
  // Command/address bus
  output logic            cke,
  output logic            cs,
  output logic [5:0]      ca
);
  logic in_cmd;

  initial
  begin
    in_cmd = 1'b0;
    cke = 1'b1;
    cs = 1'b0;
    ca = 6'h2A;
  end

  // Deselected bus never holds a stale value that could pass for a code
  always @(negedge sys_clk)
  begin
    if (!in_cmd)
      ca <= ~ca;
  end

  // Both edges of a command are sent together, never cut short
  task automatic issue(input logic [5:0] first, input logic [5:0] second);
    in_cmd = 1'b1;
    cs = 1'b1;
    ca = first;
    @(posedge sys_clk);
    #1;
    cs = 1'b0;
    ca = second;
    @(posedge sys_clk);
    #1;
    in_cmd = 1'b0;
  endtask : issue
endmodule : drt_ctl_model

// File: tb.sv
// Self-checking bench for the refresh and precharge timing block
`timescale 1ns/1ps
module tb;
  import drt_pkg::*;
  logic              sys_clk;
  logic              sys_rst;
  logic              cke;
  logic              cs;
  logic [5:0]        ca;
  logic              reset_cmd;
  logic              sr_exit;
  logic              cmd_accept;
  logic              cmd_reject;
  logic [NBANK-1:0]  bank_active;
  logic [NBANK-1:0]  bank_refreshing;
  logic [NBANK-1:0]  per_bank_refresh_mask;
  logic              all_bank_refresh_busy;
  logic              self_refresh;
  logic signed [4:0] refresh_balance;
  logic              balance_err;
  logic signed [4:0] bal;
  int                errors;
  int                checks;
  int                cycles;
  logic [2:0]        order [7] = '{3'h3, 3'h1, 3'h0, 3'h2, 3'h4, 3'h7, 3'h5};

  drt_ctl_model u_drt_ctl_model (.sys_clk(sys_clk), .cke(cke), .cs(cs), .ca(ca));

  drt_refresh_timing u_drt_refresh_timing (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cke(cke), .cs(cs), .ca(ca),
    .reset_cmd(reset_cmd), .sr_exit(sr_exit), .cmd_accept(cmd_accept),
    .cmd_reject(cmd_reject), .bank_active(bank_active),
    .bank_refreshing(bank_refreshing), .per_bank_refresh_mask(per_bank_refresh_mask),
    .all_bank_refresh_busy(all_bank_refresh_busy), .self_refresh(self_refresh),
    .refresh_balance(refresh_balance), .balance_err(balance_err));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic give_verdict;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask : idle

  task automatic pulse(input logic sel);
    if (sel)
      sr_exit = 1'b1;
    else
      reset_cmd = 1'b1;
    idle(1);
    sr_exit = 1'b0;
    reset_cmd = 1'b0;
    idle(1);
  endtask : pulse

  task automatic do_reset;
    sys_rst = 1'b1;
    idle(5);
    sys_rst = 1'b0;
  endtask : do_reset

  // Second edges of consecutive calls are 3 cycles apart
  task automatic go(input logic [5:0] f, input logic [5:0] s, input logic exp);
    u_drt_ctl_model.issue(f, s);
    // The answer stands for the one cycle right after the second edge
    check(cmd_accept === exp && cmd_reject === !exp, "command answer");
    @(posedge sys_clk);
    #1;
  endtask : go

  // Open bank 0, write to it with auto precharge, then try a command off cycles later
  task automatic probe(input logic [5:0] f, input logic [5:0] s, input int off,
                       input logic exp);
    go(6'h01, 6'h00, 1'b1);
    go(6'h04, 6'h20, 1'b1);
    idle(off - 3);
    go(f, s, exp);
    idle(25);
    go(6'h10, 6'h00, 1'b1);
  endtask : probe

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      errors++;
      give_verdict();
    end
  end

  initial
  begin
    errors = 0;
    checks = 0;
    cycles = 0;
    reset_cmd = 1'b0;
    sr_exit = 1'b0;
    do_reset();
    check(cmd_accept === 1'b0 && per_bank_refresh_mask === 8'h00 && bank_active === 8'h00 &&
          self_refresh === 1'b0 && refresh_balance === 5'h00, "reset values");
    idle(9 * REFI_CK + 5);
    check(refresh_balance === 5'h17 && balance_err === 1'b1, "postponed");
    do_reset();
    for (int i = 0; i < 7; i++)
    begin
      go(6'h08, {3'h0, order[i]}, 1'b1);
      check(bank_refreshing[order[i]] === 1'b1 && per_bank_refresh_mask[order[i]] === 1'b1,
            "bank refresh");
      if (i == 0)
        go(6'h08, 6'h03, 1'b0);
    end
    check(per_bank_refresh_mask === 8'hBF && refresh_balance === 5'h07, "mask");
    go(6'h28, 6'h00, 1'b1);
    check(per_bank_refresh_mask === 8'h00 && all_bank_refresh_busy === 1'b1, "all bank refresh");
    idle(3);
    go(6'h08, 6'h06, 1'b1);
    check(refresh_balance === 5'h09 && balance_err === 1'b1, "pulled in");
    pulse(1'b0);
    check(per_bank_refresh_mask === 8'h00, "reset command");
    go(6'h01, 6'h01, 1'b1);
    check(bank_active[1] === 1'b1, "open bank");
    go(6'h18, 6'h00, 1'b0);
    go(6'h28, 6'h00, 1'b0);
    go(6'h10, 6'h01, 1'b1);
    go(6'h08, 6'h02, 1'b1);
    go(6'h18, 6'h00, 1'b1);
    check(self_refresh === 1'b1, "self refresh");
    bal = refresh_balance;
    idle(2 * REFI_CK);
    check(refresh_balance === bal, "frozen balance");
    go(6'h01, 6'h01, 1'b0);
    pulse(1'b1);
    check(self_refresh === 1'b0 && per_bank_refresh_mask === 8'h00, "exit");
    go(6'h01, 6'h01, 1'b1);
    probe(6'h02, 6'h00, 3, 1'b0);
    probe(6'h04, 6'h00, 3, 1'b0);
    probe(6'h10, 6'h00, 3, 1'b0);
    probe(6'h0C, 6'h00, 3, 1'b0);
    probe(6'h10, 6'h00, 17, 1'b0);
    probe(6'h10, 6'h00, 18, 1'b1);
    probe(6'h0C, 6'h01, 8, 1'b1);
    probe(6'h01, 6'h00, 18, 1'b0);
    probe(6'h01, 6'h00, 19, 1'b1);
    probe(6'h02, 6'h01, 17, 1'b0);
    probe(6'h02, 6'h01, 18, 1'b1);
    probe(6'h04, 6'h01, 8, 1'b1);
    idle(1);
    go(6'h10, 6'h02, 1'b1);
    idle(1);
    go(6'h30, 6'h00, 1'b1);
    go(6'h10, 6'h03, 1'b0);
    check(bank_active === 8'h00, "all closed");
    give_verdict();
  end
endmodule : tb
